// >>> hw/crm_pkg.sv
// constants for the cyclic register mapper
// assumes one 100 MHz clock shared by the scanner port, the register port and apb
package crm_pkg;
    localparam int CRM_CLK_MHZ = 100;
    localparam int CRM_LIST_LEN = 8;
    // least request spacing, small drives per register pair and large drives flat
    localparam int CRM_PAIR_US = 4000;
    localparam int CRM_FAST_US = 1000;
    localparam int CRM_PAIR_CYC = CRM_PAIR_US * CRM_CLK_MHZ;
    localparam int CRM_FAST_CYC = CRM_FAST_US * CRM_CLK_MHZ;
    // assembly class and its two instances
    localparam logic [7:0] CRM_ASM_CLASS = 8'h04;
    localparam logic [7:0] CRM_INST_WR = 8'h64;
    localparam logic [7:0] CRM_INST_RD = 8'h65;
    // register numbers with fixed meaning
    localparam logic [31:0] CRM_REG_MODE = 32'h0000_0002;
    localparam logic [31:0] CRM_REG_POS = 32'h0000_0003;
    localparam logic [31:0] CRM_REG_ERRSTAT = 32'h0000_0023;
    localparam logic [31:0] CRM_REG_RSV36 = 32'h0000_0024;
    localparam logic [31:0] CRM_REG_RSV211 = 32'h0000_00d3;
    localparam logic [31:0] CRM_MOD_BASE = 32'h0001_0000;
    localparam logic [31:0] CRM_MODE_POSITION = 32'h0000_0002;
    // apb byte offsets
    localparam logic [7:0] CRM_OFS_CTRL = 8'h00;
    localparam logic [7:0] CRM_OFS_STATUS = 8'h04;
    localparam logic [7:0] CRM_OFS_INT_STAT = 8'h08;
    localparam logic [7:0] CRM_OFS_INT_MASK = 8'h0c;
    localparam logic [7:0] CRM_OFS_OP_MODE = 8'h10;
    localparam logic [7:0] CRM_OFS_RD_LIST = 8'h20;
    localparam logic [7:0] CRM_OFS_WR_LIST = 8'h40;
    // control bits
    localparam int CRM_CTRL_EN = 0;
    localparam int CRM_CTRL_SMALL = 1;
    localparam logic [31:0] CRM_CTRL_RESET = 32'h0000_0001;
    // event bits of int_stat and int_mask
    localparam int CRM_EV_DONE = 0;
    localparam int CRM_EV_OVERRUN = 1;
    localparam int CRM_EV_ORDER = 2;
    localparam int CRM_EV_FORBID = 3;
    localparam int CRM_EV_INSERT = 4;
    localparam int CRM_EV_BADREQ = 5;
    localparam int CRM_EV_W = 6;
    typedef enum logic [2:0] {CRM_IDLE, CRM_WR_GET, CRM_WR_REG, CRM_RD_REG, CRM_RD_PUT,
        CRM_DONE} crm_state_t;
endpackage : crm_pkg

// >>> hw/crm_mapper.sv
// cyclic register mapper: assembly frames from the scanner to the drive register port
// assumes scanner and register port logic on SYS_CLK; apb master on SYS_CLK
// How it works
// - error and status register 35 always travels in the read data.
// - read list without 35 gets 35 appended by the device.
// - cyclic frames are accepted only through assembly class 0x04.
// - module register number is sub-index times 65536; sub-index goes out.
// - eight read and eight write list entries, each one register.
// - input words flow drive to scanner, output words scanner to drive.
// - a zero entry ends its list; it and later entries are ignored.
// - every cyclic word is four bytes, thirty-two bits.
// - module entries add nothing to the least interval.
// - mode 0 passive, 1 velocity, 2 position; position acted on only in 2.
// - instance 0x64 carries written data, 0x65 carries read-back data.
module crm_mapper
    import crm_pkg::*;
#(
    parameter int N = crm_pkg::CRM_LIST_LEN,
    parameter int PAIR_CYC = crm_pkg::CRM_PAIR_CYC,
    parameter int FAST_CYC = crm_pkg::CRM_FAST_CYC
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // scanner frame requests
    input wire logic FRAME_REQ,
    input wire logic [7:0] FRAME_CLASS,
    input wire logic [7:0] FRAME_INST,
    output logic FRAME_DONE,
    output logic FRAME_DROP,
    // output words, scanner to drive
    input wire logic OUT_VALID,
    input wire logic [31:0] OUT_WORD,
    output logic OUT_READY,
    // input words, drive to scanner
    output logic IN_VALID,
    output logic [31:0] IN_WORD,
    input wire logic IN_READY,
    // drive register port
    output logic REG_REQ,
    output logic REG_WE,
    output logic REG_MODULE,
    output logic [31:0] REG_NUM,
    output logic [31:0] REG_WDATA,
    input wire logic REG_ACK,
    input wire logic [31:0] REG_RDATA,
    // interrupt
    output logic IRQ
);
    import crm_pkg::*;

    logic [31:0] rd_list [N];
    logic [31:0] wr_list [N];
    logic [31:0] ctrl, op_mode, gap, prdata_q;
    logic [CRM_EV_W-1:0] int_stat, int_mask;
    crm_state_t state;
    logic [4:0] idx;
    logic [31:0] word_q;
    logic done_q, drop_q;
    logic [31:0] next_rd_list [N];
    logic [31:0] next_wr_list [N];
    logic [31:0] next_ctrl, next_op_mode, next_gap, next_prdata_q, next_word_q;
    logic [CRM_EV_W-1:0] next_int_stat, next_int_mask, ev;
    crm_state_t next_state;
    logic [4:0] next_idx;
    logic next_done_q, next_drop_q;
    // list decode
    logic [4:0] rd_len, wr_len, rd_total, rd_mot, wr_mot, pairs;
    logic has35, order_bad, forbid, rd_stop, wr_stop, rd_mod_seen, wr_mod_seen;
    logic [31:0] interval, cur_ent;
    logic apb_wr, apb_rd_setup, unmapped, start_ok, is_wr_inst, is_rd_inst;
    logic [7:0] li;

    // first zero ends a list, so the lengths also give the packed order
    always_comb begin
        rd_len = 5'd0;
        wr_len = 5'd0;
        rd_mot = 5'd0;
        wr_mot = 5'd0;
        has35 = 1'b0;
        order_bad = 1'b0;
        forbid = 1'b0;
        rd_stop = 1'b0;
        wr_stop = 1'b0;
        rd_mod_seen = 1'b0;
        wr_mod_seen = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (rd_list[i] == 32'h0000_0000) rd_stop = 1'b1;
            if (!rd_stop) begin
                rd_len = rd_len + 5'd1;
                if (rd_list[i] == CRM_REG_ERRSTAT) has35 = 1'b1;
                if (rd_list[i] >= CRM_MOD_BASE) begin
                    rd_mod_seen = 1'b1;
                end else begin
                    rd_mot = rd_mot + 5'd1;
                    if (rd_mod_seen) order_bad = 1'b1;
                end
            end
            if (wr_list[i] == 32'h0000_0000) wr_stop = 1'b1;
            if (!wr_stop) begin
                wr_len = wr_len + 5'd1;
                if (wr_list[i] == CRM_REG_ERRSTAT || wr_list[i] == CRM_REG_RSV36
                    || wr_list[i] == CRM_REG_RSV211) forbid = 1'b1;
                if (wr_list[i] >= CRM_MOD_BASE) begin
                    wr_mod_seen = 1'b1;
                end else begin
                    wr_mot = wr_mot + 5'd1;
                    if (wr_mod_seen) order_bad = 1'b1;
                end
            end
        end
        rd_total = has35 ? rd_len : rd_len + 5'd1;
        pairs = (rd_mot > wr_mot) ? rd_mot : wr_mot;
    end

    // small drives pay per motor pair; large ones are bounded by the network
    assign interval = ctrl[CRM_CTRL_SMALL] ? PAIR_CYC * 32'(pairs) : 32'(FAST_CYC);
    assign is_wr_inst = FRAME_INST == CRM_INST_WR;
    assign is_rd_inst = FRAME_INST == CRM_INST_RD;
    assign cur_ent = (state == CRM_RD_REG || state == CRM_RD_PUT)
        ? ((idx < rd_len) ? rd_list[idx[2:0]] : CRM_REG_ERRSTAT)
        : wr_list[idx[2:0]];
    assign start_ok = FRAME_REQ && ctrl[CRM_CTRL_EN] && state == CRM_IDLE
        && FRAME_CLASS == CRM_ASM_CLASS && (is_rd_inst || (is_wr_inst && gap >= interval));
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd_setup = PSEL && !PENABLE;
    assign li = PADDR & 8'h1f;
    assign unmapped = PADDR[1:0] != 2'b00 || (PADDR > CRM_OFS_OP_MODE && PADDR < CRM_OFS_RD_LIST)
        || PADDR >= (CRM_OFS_WR_LIST + 8'(4 * N))
        || (PADDR >= CRM_OFS_RD_LIST && li >= 8'(4 * N));

    always_comb begin
        next_rd_list = rd_list;
        next_wr_list = wr_list;
        next_ctrl = ctrl;
        next_int_mask = int_mask;
        next_op_mode = op_mode;
        next_state = state;
        next_idx = idx;
        next_word_q = word_q;
        next_done_q = 1'b0;
        next_drop_q = 1'b0;
        next_prdata_q = prdata_q;
        next_gap = (gap == 32'hffff_ffff) ? gap : gap + 32'd1;
        ev = '0;
        case (state)
            CRM_IDLE: begin
                if (start_ok) begin
                    next_idx = 5'd0;
                    ev[CRM_EV_ORDER] = order_bad;
                    ev[CRM_EV_FORBID] = forbid;
                    if (is_wr_inst) begin
                        next_gap = 32'd0;
                        next_state = (wr_len == 5'd0) ? CRM_DONE : CRM_WR_GET;
                    end else begin
                        ev[CRM_EV_INSERT] = !has35;
                        next_state = CRM_RD_REG;
                    end
                end else if (FRAME_REQ) begin
                    next_drop_q = 1'b1;
                    ev[CRM_EV_BADREQ] = FRAME_CLASS != CRM_ASM_CLASS || !(is_wr_inst || is_rd_inst);
                    ev[CRM_EV_OVERRUN] = is_wr_inst && gap < interval;
                end
            end
            CRM_WR_GET: begin
                if (OUT_VALID) begin
                    next_word_q = OUT_WORD;
                    if (cur_ent == CRM_REG_MODE) next_op_mode = OUT_WORD;
                    // position is only acted on in position mode
                    if (cur_ent == CRM_REG_POS && op_mode != CRM_MODE_POSITION) begin
                        next_idx = idx + 5'd1;
                        next_state = (idx + 5'd1 == wr_len) ? CRM_DONE : CRM_WR_GET;
                    end else begin
                        next_state = CRM_WR_REG;
                    end
                end
            end
            CRM_WR_REG: begin
                if (REG_ACK) begin
                    next_idx = idx + 5'd1;
                    next_state = (idx + 5'd1 == wr_len) ? CRM_DONE : CRM_WR_GET;
                end
            end
            CRM_RD_REG: begin
                if (REG_ACK) begin
                    next_word_q = REG_RDATA;
                    next_state = CRM_RD_PUT;
                end
            end
            CRM_RD_PUT: begin
                if (IN_READY) begin
                    next_idx = idx + 5'd1;
                    next_state = (idx + 5'd1 == rd_total) ? CRM_DONE : CRM_RD_REG;
                end
            end
            CRM_DONE: begin
                next_done_q = 1'b1;
                ev[CRM_EV_DONE] = 1'b1;
                next_state = CRM_IDLE;
            end
            default: next_state = CRM_IDLE;
        endcase
        // apb: read data latched in setup, write takes effect in access
        if (apb_rd_setup) begin
            next_prdata_q = 32'h0000_0000;
            case (PADDR)
                CRM_OFS_CTRL: next_prdata_q = ctrl;
                CRM_OFS_STATUS: next_prdata_q = {20'h0_0000, 2'b00, state != CRM_IDLE,
                    rd_total, wr_len[3:0]};
                CRM_OFS_INT_STAT: next_prdata_q = 32'(int_stat);
                CRM_OFS_INT_MASK: next_prdata_q = 32'(int_mask);
                CRM_OFS_OP_MODE: next_prdata_q = op_mode;
                default: begin
                    if (!unmapped && PADDR >= CRM_OFS_WR_LIST) next_prdata_q = wr_list[li[4:2]];
                    else if (!unmapped && PADDR >= CRM_OFS_RD_LIST)
                        next_prdata_q = rd_list[li[4:2]];
                end
            endcase
        end
        // set wins over a write-one clear in the same cycle
        next_int_stat = int_stat | ev;
        if (apb_wr && !unmapped) begin
            case (PADDR)
                CRM_OFS_CTRL: next_ctrl = PWDATA;
                CRM_OFS_INT_STAT: next_int_stat = (int_stat & ~PWDATA[CRM_EV_W-1:0]) | ev;
                CRM_OFS_INT_MASK: next_int_mask = PWDATA[CRM_EV_W-1:0];
                default: begin
                    if (PADDR >= CRM_OFS_WR_LIST) next_wr_list[li[4:2]] = PWDATA;
                    else if (PADDR >= CRM_OFS_RD_LIST) next_rd_list[li[4:2]] = PWDATA;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            for (int i = 0; i < N; i++) begin
                rd_list[i] <= 32'h0000_0000;
                wr_list[i] <= 32'h0000_0000;
            end
            ctrl <= CRM_CTRL_RESET;
            int_stat <= '0;
            int_mask <= '0;
            op_mode <= 32'h0000_0000;
            state <= CRM_IDLE;
            idx <= 5'd0;
            word_q <= 32'h0000_0000;
            done_q <= 1'b0;
            drop_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            gap <= 32'hffff_ffff;
        end else begin
            rd_list <= next_rd_list;
            wr_list <= next_wr_list;
            ctrl <= next_ctrl;
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
            op_mode <= next_op_mode;
            state <= next_state;
            idx <= next_idx;
            word_q <= next_word_q;
            done_q <= next_done_q;
            drop_q <= next_drop_q;
            prdata_q <= next_prdata_q;
            gap <= next_gap;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && unmapped;
    assign FRAME_DONE = done_q;
    assign FRAME_DROP = drop_q;
    assign OUT_READY = state == CRM_WR_GET;
    assign IN_VALID = state == CRM_RD_PUT;
    assign IN_WORD = word_q;
    assign REG_REQ = state == CRM_WR_REG || state == CRM_RD_REG;
    assign REG_WE = state == CRM_WR_REG;
    // module entries leave as their sub-index
    assign REG_MODULE = cur_ent >= CRM_MOD_BASE;
    assign REG_NUM = REG_MODULE ? {16'h0000, cur_ent[31:16]} : cur_ent;
    assign REG_WDATA = word_q;
    assign IRQ = |(int_stat & int_mask);

    a_status_insert: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (state == CRM_RD_REG && idx == rd_len && !has35) |-> REG_NUM == CRM_REG_ERRSTAT)
        else $error("status register not appended to read data");
    a_class_gate: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (state == CRM_IDLE && FRAME_REQ && FRAME_CLASS != CRM_ASM_CLASS)
        |=> state == CRM_IDLE && FRAME_DROP)
        else $error("non-assembly frame was accepted");
    a_module_num: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (REG_REQ && REG_MODULE) |-> REG_NUM == 32'(cur_ent >> 16) && cur_ent > 32'h0000_ffff)
        else $error("module register number not reduced to sub-index");
    a_zero_stop: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (REG_REQ && REG_WE) |-> idx < wr_len && wr_list[idx[2:0]] != 32'h0000_0000)
        else $error("write past the end of the write list");
    a_word_count: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (state == CRM_RD_PUT && IN_READY && idx + 5'd1 == rd_total) |=> state == CRM_DONE
        ##1 FRAME_DONE)
        else $error("read frame did not close after its last word");
    a_word_pass: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (state == CRM_RD_REG && REG_ACK) |=> IN_VALID && IN_WORD == $past(REG_RDATA))
        else $error("read word not passed whole");
    a_pos_gate: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (REG_REQ && REG_WE && !REG_MODULE && REG_NUM == CRM_REG_POS)
        |-> op_mode == CRM_MODE_POSITION)
        else $error("position written outside position mode");
    a_direction: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !(OUT_READY && IN_VALID) && !(IN_VALID && REG_WE))
        else $error("input and output phases overlap");
    a_overrun: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (state == CRM_IDLE && FRAME_REQ && is_wr_inst && gap < interval)
        |=> FRAME_DROP && int_stat[CRM_EV_OVERRUN] && state == CRM_IDLE)
        else $error("early frame was not dropped");
endmodule // crm_mapper

// >>> verification/crm_regfile_model.sv
// drive register file stand-in for the register port of the mapper
// assumes the mapper holds reg_req and its qualifiers until reg_ack is seen
module crm_regfile_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic reg_module,
    input wire logic [31:0] reg_num,
    input wire logic [31:0] reg_wdata,
    output logic reg_ack,
    output logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] lat;
    logic [1:0] cnt;
    int wr_count;
    logic [31:0] last_num;
    logic last_mod;
    logic [31:0] last_data;
    logic [31:0] pos_data;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_ack <= 1'b0;
            reg_rdata <= 32'h0000_0000;
            lat <= 2'h0;
            cnt <= 2'h0;
            wr_count <= 0;
            pos_data <= 32'h0000_0000;
        end else if (reg_req && !reg_ack && cnt == lat) begin
            // latency walks 0..3 cycles so prompt and slow answers both occur
            reg_ack <= 1'b1;
            cnt <= 2'h0;
            lat <= lat + 2'h1;
            if (reg_we) begin
                wr_count <= wr_count + 1;
                last_num <= reg_num;
                last_mod <= reg_module;
                last_data <= reg_wdata;
                if (!reg_module && reg_num == 32'h0000_0003) begin
                    pos_data <= reg_wdata;
                end
            end else begin
                reg_rdata <= {8'h5a, 7'h00, reg_module, reg_num[15:0]};
            end
        end else begin
            reg_ack <= 1'b0;
            if (reg_req && !reg_ack) begin
                cnt <= cnt + 2'h1;
            end
            // stale data is scrambled so nobody can lean on it
            reg_rdata <= ~reg_rdata;
        end
    end
endmodule // crm_regfile_model

// >>> verification/cyclic_register_mapper_bench.sv
// self-checking bench for crm_mapper: apb register access and assembly frames
// assumes the drive register port is answered by crm_regfile_model
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module cyclic_register_mapper_bench
    import crm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] MC = 32'h000f_0000;
    logic sys_clk, resetn, psel, penable, pwrite, frame_req, out_valid, in_ready, reg_ack;
    logic [7:0] paddr, frame_class, frame_inst;
    logic [31:0] pwdata, out_word, reg_rdata, prdata, in_word, reg_num, reg_wdata, q;
    logic pready, pslverr, frame_done, frame_drop, out_ready, in_valid, reg_req, reg_we;
    logic reg_module, irq, e, got_done, got_drop;
    logic [31:0] wq[$];
    logic [31:0] rq[$];
    logic [31:0] ex[4];
    int err_total, comparisons, n0, k;
    time t_req;
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    crm_mapper #(.PAIR_CYC(40), .FAST_CYC(10)) DUT (.SYS_CLK(sys_clk), .RESETN(resetn),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FRAME_REQ(frame_req),
        .FRAME_CLASS(frame_class), .FRAME_INST(frame_inst), .FRAME_DONE(frame_done),
        .FRAME_DROP(frame_drop), .OUT_VALID(out_valid), .OUT_WORD(out_word),
        .OUT_READY(out_ready), .IN_VALID(in_valid), .IN_WORD(in_word), .IN_READY(in_ready),
        .REG_REQ(reg_req), .REG_WE(reg_we), .REG_MODULE(reg_module), .REG_NUM(reg_num),
        .REG_WDATA(reg_wdata), .REG_ACK(reg_ack), .REG_RDATA(reg_rdata), .IRQ(irq));
    crm_regfile_model model (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
        .reg_we(reg_we), .reg_module(reg_module), .reg_num(reg_num), .reg_wdata(reg_wdata),
        .reg_ack(reg_ack), .reg_rdata(reg_rdata));
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait states are the slave's choice; only the watchdog ends a hang
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, x, q)
    endtask
    task automatic setl(input logic [7:0] base, input logic [31:0] v[5]);
        int i;
        for (i = 0; i < 5; i++) apb(1'b1, base + 8'(4 * i), v[i]);
    endtask
    task automatic frame(input logic [7:0] cls, input logic [7:0] inst);
        int i;
        int j;
        logic taken;
        rq = {};
        got_done = 1'b0;
        got_drop = 1'b0;
        i = 0;
        @(posedge sys_clk);
        frame_req <= 1'b1;
        frame_class <= cls;
        frame_inst <= inst;
        t_req = $time;
        @(posedge sys_clk);
        frame_req <= 1'b0;
        if (inst == CRM_INST_WR && wq.size() > 0) begin
            out_valid <= 1'b1;
            out_word <= wq[0];
        end
        for (j = 0; j < 200 && !got_done && !got_drop; j++) begin
            #1;
            if (in_valid === 1'b1 && in_ready) rq.push_back(in_word);
            if (frame_done === 1'b1) got_done = 1'b1;
            if (frame_drop === 1'b1) got_drop = 1'b1;
            taken = out_valid && out_ready === 1'b1;
            @(posedge sys_clk);
            // stall the input side every other cycle
            in_ready <= !in_ready;
            if (taken) begin
                i++;
                if (i < wq.size()) out_word <= wq[i];
                else out_valid <= 1'b0;
            end
        end
        out_valid <= 1'b0;
    endtask
    function automatic logic [31:0] rdw(input logic m, input logic [15:0] n);
        return {8'h5a, 7'h00, m, n};
    endfunction
    initial begin
        {resetn, psel, penable, pwrite, frame_req, out_valid} = 6'h00;
        {paddr, frame_class, frame_inst, pwdata, out_word} = '0;
        in_ready = 1'b1;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rdc("ctrl", CRM_OFS_CTRL, CRM_CTRL_RESET);
        rdc("read entry 7", CRM_OFS_RD_LIST + 8'h1c, 32'h0000_0000);
        rdc("write entry 7", CRM_OFS_WR_LIST + 8'h1c, 32'h0000_0000);
        apb(1'b0, 8'h60, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, e)
        $display("test reset finished");
        setl(CRM_OFS_RD_LIST, '{32'h0000_000a, 32'h0000_000c, MC, 32'h0, 32'h0000_0014});
        apb(1'b1, CRM_OFS_INT_MASK, 32'h0000_0010);
        frame(CRM_ASM_CLASS, CRM_INST_RD);
        ex = '{rdw(1'b0, 16'h000a), rdw(1'b0, 16'h000c), rdw(1'b1, 16'h000f), rdw(1'b0, 16'h0023)};
        `CHK("read words", 4, rq.size())
        for (k = 0; k < 4; k++) `CHK("read word", ex[k], rq[k])
        rdc("status", CRM_OFS_STATUS, 32'h0000_0040);
        rdc("int stat", CRM_OFS_INT_STAT, 32'h0000_0011);
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, CRM_OFS_INT_STAT, 32'h0000_003f);
        @(posedge sys_clk);
        `CHK("irq cleared", 1'b0, irq)
        setl(CRM_OFS_RD_LIST, '{32'h0000_0023, 32'h0, 32'h0, 32'h0, 32'h0});
        frame(CRM_ASM_CLASS, CRM_INST_RD);
        `CHK("single word", 1, rq.size())
        `CHK("status word", rdw(1'b0, 16'h0023), rq[0])
        `CHK("status low half", 35, int'($signed(rq[0][15:0])))
        rdc("no insert", CRM_OFS_INT_STAT, 32'h0000_0001);
        $display("test read finished");
        apb(1'b1, CRM_OFS_INT_STAT, 32'h0000_003f);
        setl(CRM_OFS_WR_LIST, '{32'h0000_0002, 32'h0000_0003, MC, 32'h0, 32'h0});
        n0 = model.wr_count;
        wq = '{32'h0000_0001, 32'h0000_004d, 32'h0000_0005};
        frame(CRM_ASM_CLASS, CRM_INST_WR);
        `CHK("write done", 1'b1, got_done)
        `CHK("writes", n0 + 2, model.wr_count)
        `CHK("module number", 32'h0000_000f, model.last_num)
        `CHK("module flag", 1'b1, model.last_mod)
        `CHK("command word", 32'h0000_0005, model.last_data)
        rdc("op mode", CRM_OFS_OP_MODE, 32'h0000_0001);
        repeat (20) @(posedge sys_clk);
        wq = '{32'h0000_0002, 32'h0000_0058, 32'h0000_0006};
        frame(CRM_ASM_CLASS, CRM_INST_WR);
        `CHK("writes", n0 + 5, model.wr_count)
        `CHK("position", 32'h0000_0058, model.pos_data)
        rdc("op mode", CRM_OFS_OP_MODE, 32'h0000_0002);
        $display("test write finished");
        apb(1'b1, CRM_OFS_INT_STAT, 32'h0000_003f);
        setl(CRM_OFS_WR_LIST, '{MC, 32'h0000_0024, 32'h0, 32'h0, 32'h0});
        repeat (20) @(posedge sys_clk);
        wq = '{32'h0000_0009, 32'h0000_0009};
        frame(CRM_ASM_CLASS, CRM_INST_WR);
        rdc("order forbid", CRM_OFS_INT_STAT, 32'h0000_000d);
        apb(1'b1, CRM_OFS_INT_STAT, 32'h0000_003f);
        frame(8'h05, CRM_INST_RD);
        `CHK("bad class", 1'b1, got_drop)
        frame(CRM_ASM_CLASS, 8'h66);
        `CHK("bad instance", 1'b1, got_drop)
        rdc("bad request", CRM_OFS_INT_STAT, 32'h0000_0020);
        apb(1'b1, CRM_OFS_CTRL, 32'h0000_0000);
        frame(CRM_ASM_CLASS, CRM_INST_RD);
        `CHK("disabled", 1'b1, got_drop)
        $display("test refuse finished");
        // no acyclic traffic while the small-drive spacing is exercised
        apb(1'b1, CRM_OFS_CTRL, 32'h0000_0003);
        setl(CRM_OFS_WR_LIST, '{32'h0000_0005, MC, 32'h0, 32'h0, 32'h0});
        apb(1'b1, CRM_OFS_INT_STAT, 32'h0000_003f);
        repeat (45) @(posedge sys_clk);
        wq = '{32'h0000_0001, 32'h0000_0002};
        frame(CRM_ASM_CLASS, CRM_INST_WR);
        n0 = int'(t_req / 10);
        `CHK("spaced frame", 1'b1, got_done)
        frame(CRM_ASM_CLASS, CRM_INST_WR);
        `CHK("early frame", 1'b1, got_drop)
        rdc("overrun", CRM_OFS_INT_STAT, 32'h0000_0003);
        while ($time < n0 * 10 + 600) @(posedge sys_clk);
        frame(CRM_ASM_CLASS, CRM_INST_WR);
        `CHK("module free", 1'b1, got_done)
        $display("test spacing finished");
        print_verdict;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        print_verdict;
    end
endmodule // cyclic_register_mapper_bench
